// File: core/gpp_port.sv
// The implementer's own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
// How it works
// - Direction one makes the pin output
// - Output pin drives latch value to pad
// - Output pin reads return latch value
// - Direction zero makes pin input, undriven
// - Input-pin writes update latch only
// - Input read: pad; RMW read: latch
// - Peripheral enable overrides latch drive
// - Peripheral-driven pin reads pad, RMW latch
// - Peripheral input use still reads pad
// - Reset clears all direction bits
// - Standby float bit forces pins Hi-Z
// - Floating standby inputs read constant low
// - Float bit zero holds pin states
// - Pull-up enable connects internal pull-up
// - Low-driving pin disconnects its pull-up
// - Open-drain high output releases pad
// - Disable zero enables comparator inputs
// - Disable one disconnects comparator inputs
// - Pins 0,1 comparator; pin 2 I2C clock
module gpp_port (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic        rmwRead,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic [3:0]  padIn,
    output logic [3:0]       padOut,
    output logic [3:0]       padOeN,
    output logic [3:0]       pullupOn,
    input  wire logic [3:0]  periphOe,
    input  wire logic [3:0]  periphOut,
    output logic [3:0]       periphIn,
    output logic             comparatorInvertingInput,
    output logic             comparatorNoninvertingInput,
    output logic             comparatorInputEnable
);
    typedef struct packed {
        logic [3:0]  dataLatch;
        logic [3:0]  direction;
        logic [1:0]  pullupEnable;
        logic        standbyPinFloat;
        logic        standbyActive;
        logic        cmpInputDisable;
        logic        wrPending;
        logic        rdPending;
        logic        rmwPending;
        logic [7:0]  addrPending;
        logic [31:0] rdata;
        logic [3:0]  padOut;
        logic [3:0]  padOeN;
        logic [3:0]  pullupOn;
        logic [3:0]  periphIn;
        logic        cmpN;
        logic        cmpP;
        logic        cmpEn;
        logic [3:0]  heldOut;
        logic [3:0]  heldOeN;
        logic [3:0]  heldPull;
    } gpp_state_s;

    gpp_state_s state_q;
    gpp_state_s state_d;

    logic [3:0] cellOut;
    logic [3:0] cellOeN;
    logic [3:0] cellPull;
    logic [3:0] padLevel;
    logic       forceFloat;

    // Pins float only in standby with the float bit set
    assign forceFloat = state_q.standbyActive & state_q.standbyPinFloat;

    // Compose a read word; reserved bits read as zero
    function automatic logic [31:0] readWord(input gpp_state_s s,
                                             input logic [7:0] addr,
                                             input logic rmw,
                                             input logic [3:0] oe,
                                             input logic [3:0] pads);
        logic [3:0] pinView;
        pinView = 4'h0;
        readWord = 32'h0000_0000;
        // Port-driven outputs read the latch; peripheral pins read the pad unless RMW
        for (int i = 0; i < gpp_pkg::PIN_COUNT; i++) begin
            if ((s.direction[i] & ~oe[i]) | rmw) begin
                pinView[i] = s.dataLatch[i];
            end else begin
                pinView[i] = pads[i];
            end
        end
        unique case (addr)
            gpp_pkg::ADDR_DATA_LATCH: begin
                readWord[3:0] = pinView;
            end
            gpp_pkg::ADDR_DIRECTION: begin
                readWord[3:0] = s.direction;
            end
            gpp_pkg::ADDR_PULLUP_ENABLE: begin
                readWord[1:0] = s.pullupEnable;
            end
            gpp_pkg::ADDR_CONTROL: begin
                readWord[gpp_pkg::CTRL_STANDBY_PIN_FLOAT_BIT] = s.standbyPinFloat;
                readWord[gpp_pkg::CTRL_STANDBY_ACTIVE_BIT]    = s.standbyActive;
                readWord[gpp_pkg::CTRL_CMP_INPUT_DISABLE_BIT] = s.cmpInputDisable;
            end
            gpp_pkg::ADDR_PAD_STATUS: begin
                readWord[3:0] = pads;
            end
            default: begin
                readWord = 32'h0000_0000;
            end
        endcase
    endfunction

    // One cell per pin for drive, pull-up and input gating
    for (genvar g = 0; g < gpp_pkg::PIN_COUNT; g++) begin : gen_pin
        gpp_pin_cell u_cell (
            .latchBit      (state_q.dataLatch[g]),
            .dirBit        (state_q.direction[g]),
            .periphOe      (periphOe[g]),
            .periphOut     (periphOut[g]),
            .openDrain     (gpp_pkg::OPEN_DRAIN_MASK[g]),
            .pullupAllowed (gpp_pkg::PULLUP_MASK[g]),
            .pullupBit     ((g < 2) ? state_q.pullupEnable[g % 2] : 1'b0),
            .forceFloat    (forceFloat),
            .padIn         (padIn[g]),
            .padOutVal     (cellOut[g]),
            .padOeN        (cellOeN[g]),
            .pullupOn      (cellPull[g]),
            .padLevel      (padLevel[g])
        );
    end

    // Bus slave, register file and pad registers, all in one next-state copy
    always_comb begin
        logic addrOk;
        addrOk = 1'b0;
        state_d = state_q;
        state_d.wrPending = 1'b0;
        state_d.rdPending = 1'b0;
        // Data phase of a write: store into the addressed register
        if (state_q.wrPending) begin
            unique case (state_q.addrPending)
                gpp_pkg::ADDR_DATA_LATCH: begin
                    state_d.dataLatch = hwdata[3:0];
                end
                gpp_pkg::ADDR_DIRECTION: begin
                    state_d.direction = hwdata[3:0];
                end
                gpp_pkg::ADDR_PULLUP_ENABLE: begin
                    state_d.pullupEnable = hwdata[1:0];
                end
                gpp_pkg::ADDR_CONTROL: begin
                    state_d.standbyPinFloat = hwdata[gpp_pkg::CTRL_STANDBY_PIN_FLOAT_BIT];
                    state_d.standbyActive   = hwdata[gpp_pkg::CTRL_STANDBY_ACTIVE_BIT];
                    state_d.cmpInputDisable = hwdata[gpp_pkg::CTRL_CMP_INPUT_DISABLE_BIT];
                end
                default: begin
                    state_d.dataLatch = state_q.dataLatch; // Unmapped and status: ignored
                end
            endcase
        end
        // Address phase: latch the request, answer with zero wait states
        addrOk = hsel & hready & (htrans == gpp_pkg::HTRANS_NONSEQ);
        if (addrOk) begin
            state_d.addrPending = haddr[7:0];
            state_d.wrPending   = hwrite;
            state_d.rdPending   = ~hwrite;
            state_d.rmwPending  = rmwRead;
            if (!hwrite) begin
                state_d.rdata = readWord(state_q, haddr[7:0], rmwRead, periphOe, padLevel);
            end
        end
        // Pads follow the cells, except in a held standby
        if (state_q.standbyActive & ~state_q.standbyPinFloat) begin
            state_d.padOut   = state_q.heldOut;
            state_d.padOeN   = state_q.heldOeN;
            state_d.pullupOn = state_q.heldPull;
        end else begin
            state_d.padOut   = cellOut;
            state_d.padOeN   = cellOeN;
            state_d.pullupOn = cellPull;
            state_d.heldOut  = cellOut;
            state_d.heldOeN  = cellOeN;
            state_d.heldPull = cellPull;
        end
        // Peripherals see the gated pad level
        state_d.periphIn = padLevel;
        // Comparator inputs on pins 0 and 1, regardless of data and direction
        state_d.cmpEn = ~state_q.cmpInputDisable & ~forceFloat;
        state_d.cmpN  = state_d.cmpEn & padLevel[0];
        state_d.cmpP  = state_d.cmpEn & padLevel[1];
    end

    // Register the whole state; reset gives every field a constant
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= '0;
            state_q.dataLatch       <= gpp_pkg::RESET_DATA_LATCH;
            state_q.direction       <= gpp_pkg::RESET_DIRECTION;
            state_q.pullupEnable    <= gpp_pkg::RESET_PULLUP;
            state_q.standbyPinFloat <= gpp_pkg::RESET_STANDBY_FLOAT;
            state_q.standbyActive   <= gpp_pkg::RESET_STANDBY_ACT;
            state_q.cmpInputDisable <= gpp_pkg::RESET_CMP_DISABLE;
            state_q.padOeN          <= 4'hF;
            state_q.heldOeN         <= 4'hF;
        end else begin
            state_q <= state_d;
        end
    end

    // hreadyout and hresp tied off; other outputs straight from flip-flops
    assign hreadyout                   = 1'b1;
    assign hresp                       = 1'b0;
    assign hrdata                      = state_q.rdata;
    assign padOut                      = state_q.padOut;
    assign padOeN                      = state_q.padOeN;
    assign pullupOn                    = state_q.pullupOn;
    assign periphIn                    = state_q.periphIn;
    assign comparatorInvertingInput    = state_q.cmpN;
    assign comparatorNoninvertingInput = state_q.cmpP;
    assign comparatorInputEnable       = state_q.cmpEn;
endmodule

// File: core/gpp_pkg.sv
package gpp_pkg;
    // Byte offsets of the AHB-Lite register words
    localparam logic [7:0] ADDR_DATA_LATCH    = 8'h00;
    localparam logic [7:0] ADDR_DIRECTION     = 8'h04;
    localparam logic [7:0] ADDR_PULLUP_ENABLE = 8'h08;
    localparam logic [7:0] ADDR_CONTROL       = 8'h0C;
    localparam logic [7:0] ADDR_PAD_STATUS    = 8'h10;
    // Port geometry
    localparam int PIN_COUNT = 4;
    localparam int REG_WIDTH = 8;
    // Control register fields
    localparam int CTRL_STANDBY_PIN_FLOAT_BIT = 0;
    localparam int CTRL_STANDBY_ACTIVE_BIT    = 1;
    localparam int CTRL_CMP_INPUT_DISABLE_BIT = 2;
    // Reset values
    localparam logic [3:0] RESET_DATA_LATCH = 4'h0;
    localparam logic [3:0] RESET_DIRECTION  = 4'h0;
    localparam logic [1:0] RESET_PULLUP     = 2'h0;
    localparam logic       RESET_STANDBY_FLOAT = 1'b0;
    localparam logic       RESET_STANDBY_ACT   = 1'b0;
    localparam logic       RESET_CMP_DISABLE   = 1'b0;
    // Pins that are open drain (the I2C pair) and that carry a pull-up
    localparam logic [3:0] OPEN_DRAIN_MASK = 4'hC;
    localparam logic [3:0] PULLUP_MASK     = 4'h3;
    localparam logic [3:0] CMP_PIN_MASK    = 4'h3;
    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
endpackage

// File: core/gpp_pin_cell.sv
`timescale 1ns/1ps
// One pad cell: chooses the pad driver and input gating for a single pin
module gpp_pin_cell (
    input  wire logic latchBit,
    input  wire logic dirBit,
    input  wire logic periphOe,
    input  wire logic periphOut,
    input  wire logic openDrain,
    input  wire logic pullupAllowed,
    input  wire logic pullupBit,
    input  wire logic forceFloat,
    input  wire logic padIn,
    output logic      padOutVal,
    output logic      padOeN,
    output logic      pullupOn,
    output logic      padLevel
);
    logic driveVal;
    logic driving;

    // Peripheral output wins over the latch when its enable is set
    always_comb begin
        driveVal = periphOe ? periphOut : latchBit;
        driving  = (periphOe | dirBit) & ~forceFloat;
        if (openDrain & driveVal) begin
            driving = 1'b0;
        end
        padOutVal = driveVal;
        padOeN    = ~driving;
        // Pull-up drops out whenever the pin pulls low, and in float standby
        pullupOn  = pullupAllowed & pullupBit & ~(driving & ~driveVal) & ~forceFloat;
        // Blocked input reads as a constant low to stop leakage
        padLevel  = forceFloat ? 1'b0 : padIn;
    end
endmodule

// File: testbench/gpp_pad_model.sv
`timescale 1ns/1ps
// Pad wires outside the port: external drivers, pull-up, floating level
module gpp_pad_model (
    input  wire logic       clk,
    input  wire logic [3:0] padOut,
    input  wire logic [3:0] padOeN,
    input  wire logic [3:0] pullupOn,
    input  wire logic [3:0] extEn,
    input  wire logic [3:0] extVal,
    output logic      [3:0] padIn
);
    logic [3:0] tgl = 4'h5;
    // A floating pad flips each cycle so no stale level passes as valid
    always_ff @(posedge clk) tgl <= ~tgl;
    // Port drive wins, then the outside world, then the pull-up
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            padIn[i] = !padOeN[i] ? padOut[i] : extEn[i] ? extVal[i] :
                       pullupOn[i] ? 1'b1 : tgl[i];
        end
    end
endmodule

// File: testbench/gpp_port_sva.sv
`timescale 1ns/1ps
// Pin checks against a register shadow snooped off the bus
module gpp_port_sva (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        rmwRead,
    input wire logic [31:0] hrdata,
    input wire logic [3:0]  padIn,
    input wire logic [3:0]  padOut,
    input wire logic [3:0]  padOeN,
    input wire logic [3:0]  pullupOn,
    input wire logic [3:0]  periphOe,
    input wire logic [3:0]  periphOut,
    input wire logic [3:0]  periphIn,
    input wire logic        comparatorInvertingInput,
    input wire logic        comparatorNoninvertingInput,
    input wire logic        comparatorInputEnable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic [7:0] aQ;
    logic       wQ;
    logic [3:0] latQ, dirQ;
    logic [2:0] ctlQ;
    wire take = hsel && hready && htrans == gpp_pkg::HTRANS_NONSEQ;
    // Shadow updates on the edge that ends the write data phase
    always_ff @(posedge clk) begin
        aQ <= haddr[7:0];
        wQ <= !srst && take && hwrite;
        if (srst) begin
            latQ <= 4'h0;
            dirQ <= 4'h0;
            ctlQ <= 3'h0;
        end else if (wQ) begin
            if (aQ == gpp_pkg::ADDR_DATA_LATCH) latQ <= hwdata[3:0];
            if (aQ == gpp_pkg::ADDR_DIRECTION) dirQ <= hwdata[3:0];
            if (aQ == gpp_pkg::ADDR_CONTROL) ctlQ <= hwdata[2:0];
        end
    end
    // Expected drive; open-drain pins release instead of driving high
    wire [3:0] val = (periphOe & periphOut) | (~periphOe & latQ);
    wire [3:0] expOeN = ~((dirQ | periphOe) & ~(gpp_pkg::OPEN_DRAIN_MASK & val));
    wire stby = ctlQ[1];
    wire flt = ctlQ[1] && ctlQ[0];
    sequence s_rd(logic r);
        take && !hwrite && haddr[7:0] == gpp_pkg::ADDR_DATA_LATCH && rmwRead == r && !stby;
    endsequence
    a_out_drive: assert property (!$past(stby) && !$past(srst) |->
        padOeN == $past(expOeN) && (padOut & ~padOeN) == $past(val & ~expOeN))
        else $error("pad drive mismatch");
    a_float_hiz: assert property ($past(flt) |->
        padOeN == 4'hF && periphIn == 4'h0 && !comparatorInputEnable)
        else $error("float standby not hi-z");
    a_hold_state: assert property ($past(stby && !ctlQ[0]) && $past(stby && !ctlQ[0], 2)
        |-> $stable(padOut) && $stable(padOeN)) else $error("standby outputs moved");
    a_pullup_low: assert property ((pullupOn & ~padOeN & ~padOut) == 4'h0)
        else $error("pull-up on a low pin");
    a_pullup_pins: assert property (pullupOn[3:2] == 2'h0)
        else $error("pull-up on pin without one");
    a_cmp_enable: assert property (!$past(stby) && !$past(srst) |->
        comparatorInputEnable == !$past(ctlQ[2])) else $error("comparator enable wrong");
    a_cmp_gate: assert property ({comparatorNoninvertingInput, comparatorInvertingInput}
        == (comparatorInputEnable ? $past(padIn[1:0]) : 2'h0)) else $error("cmp input wrong");
    a_rmw_read: assert property (s_rd(1'b1) |=> hrdata == {28'h0, $past(latQ)})
        else $error("rmw read not latch");
    a_out_read: assert property (s_rd(1'b0) |=> hrdata[31:4] == 28'h0 &&
        (hrdata[3:0] & $past(dirQ & ~periphOe)) == $past(latQ & dirQ & ~periphOe))
        else $error("output pin read not latch");
endmodule
bind gpp_port gpp_port_sva gpp_port_sva_inst (.clk(clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .rmwRead(rmwRead), .hrdata(hrdata), .padIn(padIn), .padOut(padOut), .padOeN(padOeN),
    .pullupOn(pullupOn), .periphOe(periphOe), .periphOut(periphOut), .periphIn(periphIn),
    .comparatorInvertingInput(comparatorInvertingInput), .comparatorNoninvertingInput(
    comparatorNoninvertingInput), .comparatorInputEnable(comparatorInputEnable));

// File: testbench/gpp_port_tb.sv
`timescale 1ns/1ps
module gpp_port_tb;
    logic clk = 0, srst = 1, hsel = 0, hwrite = 0, rmwRead = 0, hready, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 0;
    logic [3:0] padIn, padOut, padOeN, pullupOn, periphIn, extEn = 0, extVal = 0;
    logic [3:0] periphOe = 0, periphOut = 0;
    logic cInv, cNon, cEn;
    int n_errors = 0, compares = 0, cyc = 0;
    gpp_port gpp_port_inst (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .rmwRead(rmwRead), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .padIn(padIn), .padOut(padOut), .padOeN(padOeN), .pullupOn(pullupOn),
        .periphOe(periphOe), .periphOut(periphOut), .periphIn(periphIn),
        .comparatorInvertingInput(cInv), .comparatorNoninvertingInput(cNon),
        .comparatorInputEnable(cEn));
    gpp_pad_model gpp_pad_model_inst (.clk(clk), .padOut(padOut), .padOeN(padOeN),
        .pullupOn(pullupOn), .extEn(extEn), .extVal(extVal), .padIn(padIn));
    initial forever #2.5 clk = ~clk;
    task automatic report_and_stop;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Timeout guard: the sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic eq(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_rdy;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
    endtask
    // One bus transfer launched on an edge: address phase, data phase, idle cycle
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic r, input logic [31:0] exp);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= gpp_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= gpp_pkg::HSIZE_WORD;
        rmwRead <= r;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        if (!w) eq(hrdata, exp);
        eq({31'h0, hresp}, 32'h0);
        hsel <= 1'b0;
        @(posedge clk);
    endtask
    // Pins lag the registers by one stage; look after both edges land
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        xfer(0, gpp_pkg::ADDR_DIRECTION, 0, 0, 32'h0);
        xfer(0, gpp_pkg::ADDR_PULLUP_ENABLE, 0, 0, 32'h0);
        xfer(0, 8'h20, 0, 0, 32'h0);
        eq(padOeN, 4'hF);
        xfer(1, gpp_pkg::ADDR_DATA_LATCH, 32'hFFFFFFF5, 0, 0);
        xfer(1, gpp_pkg::ADDR_DIRECTION, 32'hF, 0, 0);
        xfer(1, gpp_pkg::ADDR_PULLUP_ENABLE, 32'h3, 0, 0);
        settle();
        eq(padOeN, 4'h4);
        eq(padOut & ~padOeN, 4'h1);
        eq(pullupOn, 4'h1);
        xfer(0, gpp_pkg::ADDR_DATA_LATCH, 0, 0, 32'h5);
        // Input mode: pin 0 rests on its pull-up, others driven outside
        xfer(1, gpp_pkg::ADDR_DIRECTION, 32'h0, 0, 0);
        extEn <= 4'hE;
        extVal <= 4'h6;
        xfer(1, gpp_pkg::ADDR_DATA_LATCH, 32'hA, 0, 0);
        settle();
        eq(padOeN, 4'hF);
        eq(pullupOn, 4'h3);
        xfer(0, gpp_pkg::ADDR_DATA_LATCH, 0, 0, 32'h7);
        xfer(0, gpp_pkg::ADDR_DATA_LATCH, 0, 1, 32'hA);
        // Peripheral takes pin 0 low; pin 1 falls back on its pull-up
        extEn <= 4'hC;
        periphOe <= 4'h1;
        settle();
        eq(padOeN, 4'hE);
        eq(pullupOn, 4'h2);
        xfer(0, gpp_pkg::ADDR_DATA_LATCH, 0, 0, 32'h6);
        xfer(0, gpp_pkg::ADDR_DATA_LATCH, 0, 1, 32'hA);
        eq({cEn, cNon, cInv}, 3'h6);
        xfer(1, gpp_pkg::ADDR_CONTROL, 32'h4, 0, 0);
        settle();
        eq({cEn, cNon, cInv}, 3'h0);
        // Standby without float: a peripheral release must not reach the pins
        xfer(1, gpp_pkg::ADDR_CONTROL, 32'h2, 0, 0);
        periphOe <= 4'h0;
        settle();
        eq(padOeN, 4'hE);
        xfer(1, gpp_pkg::ADDR_CONTROL, 32'h3, 0, 0);
        settle();
        eq(padOeN, 4'hF);
        eq(periphIn, 4'h0);
        xfer(1, gpp_pkg::ADDR_CONTROL, 32'h0, 0, 0);
        settle();
        eq(padOeN, 4'hF);
        // Peripheral drives pin 0 high over an output pin whose latch is low
        @(posedge clk);
        periphOe <= 4'h1;
        periphOut <= 4'h1;
        xfer(1, gpp_pkg::ADDR_DIRECTION, 32'hF, 0, 0);
        settle();
        eq(padOeN, 4'h8);
        xfer(0, gpp_pkg::ADDR_DATA_LATCH, 0, 0, 32'hB);
        report_and_stop();
    end
endmodule
